// [hw/art_top.sv]
// Auto-reload PWM timer: prescaler, counter, four PWM channels and two captures.
// What this block does
// R01: Eight-bit counter steps once per prescaler output tick.
// R02: Software reads or writes the running counter without stopping it.
// R03: Overflow reloads the counter from the reload value; prescaler untouched.
// R04: Seven-bit prescaler, tap chosen by three-bit field divides by two to the n.
// R05: Prescaler input is CPU clock or the external clock pin.
// R06: Enable clear freezes prescaler and counter; set lets them run.
// R07: Reset clears counter and prescaler and picks the CPU clock.
// R08: Force reload with enable, or counter write, clears the prescaler.
// R09: No software path reads or writes the prescaler.
// R10: Four hidden compare registers load from duty registers at each overflow.
// R11: Output enable makes the channel pin a driven push-pull output.
// R12: All channels share one period of 256 minus reload counts.
// R13: Overflow sets pin by polarity; compare match restores the prior level.
// R14: Software must set compare above reload for a pulse to appear.
// R15: Full resolution needs reload zero; polarity flip gives 0 and 100 percent.
// R16: PWM generation stops while the system is in Halt.
// R17: Every overflow sets the sticky flag; enabled flag raises an interrupt.
// R18: Externally clocked, the reload value sets events counted per overflow.
// R19: Software clears the enable before Halt to avoid spurious counts.
// R20: Selected capture edge latches counter, sets flag, interrupts if enabled.
// R21: Captured value is locked and request held until software reads it.
// R22: Capture pins act as edge interrupts that wake the system from Halt.
// R23: Reading the control and status register clears the overflow flag.
// R24: Force reload bit is write-only and always reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "art_params.svh"
module art_top #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_count_clock_pin,
  input wire logic [CAPTURES-1:0] capture_input_pin,
  input wire logic halt_mode,
  output logic [CHANNELS-1:0] pwm_output_pin,
  output logic [CHANNELS-1:0] pwm_output_oe,
  output logic overflow_irq,
  output logic capture_irq,
  output logic halt_wakeup
);
  logic [7:0] csr_q;
  logic [7:0] counter_q;
  logic [7:0] reload_q;
  logic [7:0] pwm_channel_control_reg_q;
  logic [7:0] duty_q [CHANNELS];
  logic [7:0] compare_q [CHANNELS];
  logic [CHANNELS-1:0] level_q;
  logic [`ART_PRESCALE_W-1:0] prescale_q;
  logic [3:0] iccsr_q;
  logic ovf_q;
  logic ext_rise;
  logic tick;
  logic in_tick;
  logic overflow;
  logic wr_csr;
  logic wr_car;
  logic force_load;
  logic [CAPTURES-1:0] cap_rise;
  logic [CAPTURES-1:0] cap_fall;
  logic [CAPTURES-1:0] cap_flag;
  logic [CAPTURES-1:0] cap_hit;
  logic [CAPTURES-1:0] cap_rd;
  logic [7:0] cap_val [CAPTURES];
  logic [7:0] rdata_d;

  wire logic counter_enable_bit = csr_q[`ART_CSR_TCE];
  wire logic external_clock_select = csr_q[`ART_CSR_EXTERNAL_CLOCK_SELECT];
  wire logic [2:0] prescale_tap_select = csr_q[`ART_CSR_CC_LO +: 3];
  wire logic overflow_irq_enable = csr_q[`ART_CSR_OIE];
  wire logic [3:0] channel_polarity = pwm_channel_control_reg_q[3:0];
  wire logic [3:0] channel_output_enable = pwm_channel_control_reg_q[7:4];

  // The external count clock is a pin, so it is synchronised and its rising edges used.
  art_sync u_ext_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(external_count_clock_pin),
    .level_q(),
    .rise(ext_rise),
    .fall()
  );

  // Register strobes.
  assign wr_csr = reg_wr && (reg_addr == `ART_ADDR_CSR);
  assign wr_car = reg_wr && (reg_addr == `ART_ADDR_CAR);
  assign force_load = wr_csr && reg_wdata[`ART_CSR_FORCE_RELOAD_BIT] && reg_wdata[`ART_CSR_TCE];

  // Prescaler input: one enable per CPU cycle, or one per external edge.
  assign in_tick = counter_enable_bit &&
    (external_clock_select ? ext_rise : 1'b1); // [R05] [R06]

  // A tap fires when all prescaler bits below it are ones, so the rate is in_tick over 2^n.
  always_comb begin
    tick = 1'b0;
    if (in_tick) begin
      if (prescale_tap_select == 3'h0) begin
        tick = 1'b1;
      end else begin
        tick = &(prescale_q | ~((7'h7f) >> (3'd7 - prescale_tap_select))); // [R04]
      end
    end
  end

  assign overflow = tick && (counter_q == 8'hff);

  // The prescaler has no read or write port; only clear events reach it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale_q <= '0; // [R07]
    end else if (force_load || wr_car) begin
      prescale_q <= '0; // [R08] [R09]
    end else if (in_tick) begin
      prescale_q <= prescale_q + 7'h01; // [R04] [R06]
    end
  end

  // Counter: software writes win, then forced load, then counting and reload.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      counter_q <= 8'h00; // [R07]
    end else if (wr_car) begin
      counter_q <= reg_wdata; // [R02]
    end else if (force_load) begin
      counter_q <= reload_q; // [R08]
    end else if (overflow) begin
      counter_q <= reload_q; // [R03] [R12] [R18]
    end else if (tick) begin
      counter_q <= counter_q + 8'h01; // [R01]
    end
  end

  // Control bits; force reload is a pulse and never stored.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csr_q <= `ART_RESET_BYTE; // [R07]
      reload_q <= `ART_RESET_BYTE;
      pwm_channel_control_reg_q <= `ART_RESET_BYTE;
      iccsr_q <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ART_ADDR_CSR: csr_q <= {reg_wdata[7:3], 1'b0, reg_wdata[1], 1'b0}; // [R24]
        `ART_ADDR_ARR: reload_q <= reg_wdata;
        `ART_ADDR_PWM_CHANNEL_CONTROL_REG: pwm_channel_control_reg_q <= reg_wdata;
        `ART_ADDR_ICCSR: iccsr_q <= reg_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Overflow flag: a new overflow wins over the clearing read in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (overflow) begin
      ovf_q <= 1'b1; // [R17]
    end else if (reg_rd && reg_addr == `ART_ADDR_CSR) begin
      ovf_q <= 1'b0; // [R23]
    end
  end

  // Duty registers are visible; compare copies follow them only at overflow to avoid glitches.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        duty_q[i] <= 8'h00;
        compare_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (reg_wr && reg_addr == (`ART_ADDR_DCR0 + 4'(i))) begin
          duty_q[i] <= reg_wdata;
        end
        if (overflow) begin
          compare_q[i] <= duty_q[i]; // [R10]
        end
      end
    end
  end

  // Channel level: overflow drives the active level, a compare match restores it.
  // A compare at or below the reload value never matches in range, so no pulse. [R14]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_q <= '0;
    end else if (!halt_mode) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (overflow) begin
          level_q[i] <= 1'b1; // [R13] [R15]
        end else if (tick && (counter_q + 8'h01) == compare_q[i]) begin
          level_q[i] <= 1'b0; // [R13]
        end
      end
    end
  end

  // Pins are registered; Halt freezes the waveform at its present level.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_output_pin <= '0;
      pwm_output_oe <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        pwm_output_pin[i] <= level_q[i] ^ !channel_polarity[i]; // [R13] [R16]
        pwm_output_oe[i] <= channel_output_enable[i]; // [R11]
      end
    end
  end

  // Capture channels, each with its own synchroniser.
  for (genvar c = 0; c < CAPTURES; c++) begin : g_cap
    art_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in(capture_input_pin[c]),
      .level_q(),
      .rise(cap_rise[c]),
      .fall(cap_fall[c])
    );
    assign cap_rd[c] = reg_rd && (reg_addr == (`ART_ADDR_ICR0 + 4'(c)));
    art_capture u_cap (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_rise(cap_rise[c]),
      .pin_fall(cap_fall[c]),
      .edge_rising(iccsr_q[`ART_ICCSR_CS_LO + c]),
      .count(counter_q),
      .rd_clear(cap_rd[c]),
      .flag_q(cap_flag[c]),
      .value_q(cap_val[c]),
      .hit(cap_hit[c])
    );
  end

  // Interrupt and wake outputs come from flip-flops.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
      halt_wakeup <= 1'b0;
    end else begin
      overflow_irq <= (ovf_q || overflow) && overflow_irq_enable; // [R17]
      capture_irq <= |(cap_flag & iccsr_q[`ART_ICCSR_CIE_LO +: 2]); // [R20] [R21]
      halt_wakeup <= halt_mode && |(cap_hit & iccsr_q[`ART_ICCSR_CIE_LO +: 2]); // [R22]
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `ART_ADDR_CSR: rdata_d = {csr_q[7:3], 1'b0, csr_q[1], ovf_q}; // [R24]
      `ART_ADDR_CAR: rdata_d = counter_q; // [R02]
      `ART_ADDR_ARR: rdata_d = reload_q;
      `ART_ADDR_PWM_CHANNEL_CONTROL_REG: rdata_d = pwm_channel_control_reg_q;
      `ART_ADDR_ICCSR: rdata_d = {2'b00, cap_flag, iccsr_q};
      `ART_ADDR_ICR0: rdata_d = cap_val[0];
      `ART_ADDR_ICR1: rdata_d = cap_val[1];
      default: begin
        if (reg_addr >= `ART_ADDR_DCR0 && reg_addr < `ART_ADDR_ICCSR) begin
          rdata_d = duty_q[reg_addr[1:0]];
        end
      end
    endcase
  end

  // Read data are registered and stand until the next read strobe.
  // Software may poll slowly, so the value must not drift between reads.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // One overflow event; several properties start from it.
  sequence ovf_event_s;
    overflow;
  endsequence

  // A read of the control register, which also clears the overflow flag.
  sequence csr_read_s;
    reg_rd && reg_addr == `ART_ADDR_CSR;
  endsequence

  // Overflow reloads the counter unless software writes it in the same cycle.
  reload_on_ovf_a: assert property (@(posedge sys_clk) disable iff (rst) // [R03]
    ovf_event_s and (!wr_car && !force_load) |=> counter_q == $past(reload_q))
    else $error("no reload");
  ovf_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    ovf_event_s |=> ovf_q)
    else $error("overflow flag not set");
  ovf_read_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
    csr_read_s and !overflow |=> !ovf_q)
    else $error("flag not cleared");
  // With the enable clear nothing moves unless software writes.
  frozen_count_a: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
    !counter_enable_bit && !reg_wr |=> $stable(counter_q) && $stable(prescale_q))
    else $error("counting while off");
  tick_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
    !counter_enable_bit |-> !tick)
    else $error("tick while stopped");
  ext_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // [R05] [R18]
    counter_enable_bit && external_clock_select && !ext_rise |-> !tick)
    else $error("tick without external edge");
  prescale_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    !in_tick && !force_load && !wr_car |=> $stable(prescale_q))
    else $error("prescaler moved");
  car_write_a: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
    wr_car |=> counter_q == $past(reg_wdata) && prescale_q == 7'h00)
    else $error("counter write lost");
  force_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R08]
    force_load && !wr_car |=> prescale_q == 7'h00 && counter_q == $past(reload_q))
    else $error("forced load");
  div_one_a: assert property (@(posedge sys_clk) disable iff (rst) // [R01] [R04]
    counter_enable_bit && !external_clock_select && prescale_tap_select == 3'h0 && !reg_wr
      && counter_q != 8'hff |=> counter_q == $past(counter_q) + 8'h01)
    else $error("no step");
  // Channel behaviour.
  compare_load_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    ovf_event_s |=> compare_q[0] == $past(duty_q[0]))
    else $error("compare not loaded");
  level_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    ovf_event_s and !halt_mode |=> &level_q)
    else $error("level not set at overflow");
  pwm_halt_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
    halt_mode |=> $stable(level_q))
    else $error("pwm ran in halt");
  // Register reads and request outputs.
  force_reload_bit_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [R24]
    csr_read_s |=> !reg_rdata[`ART_CSR_FORCE_RELOAD_BIT])
    else $error("force bit read");
  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed");
  ovf_irq_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    ovf_q && overflow_irq_enable |=> overflow_irq)
    else $error("overflow request missing");
  ovf_irq_off_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    !overflow_irq_enable |=> !overflow_irq)
    else $error("overflow request while disabled");
  cap_irq_a: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
    (|(cap_flag & iccsr_q[`ART_ICCSR_CIE_LO +: 2])) |=> capture_irq)
    else $error("capture request missing");
  halt_wake_a: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
    halt_mode && (|(cap_hit & iccsr_q[`ART_ICCSR_CIE_LO +: 2])) |=> halt_wakeup)
    else $error("no wake from halt");
  no_wake_a: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
    !halt_mode |=> !halt_wakeup)
    else $error("wake outside halt");
endmodule
`default_nettype wire

// [hw/art_params.svh]
// Register offsets, field positions and reset values for the auto-reload PWM timer.
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH
`define ART_ADDR_CSR 4'h0
`define ART_ADDR_CAR 4'h1
`define ART_ADDR_ARR 4'h2
`define ART_ADDR_PWM_CHANNEL_CONTROL_REG 4'h3
`define ART_ADDR_DCR0 4'h4
`define ART_ADDR_ICCSR 4'h8
`define ART_ADDR_ICR0 4'h9
`define ART_ADDR_ICR1 4'ha
`define ART_ADDR_HALT 4'hb
`define ART_CSR_EXTERNAL_CLOCK_SELECT 7
`define ART_CSR_CC_LO 4
`define ART_CSR_TCE 3
`define ART_CSR_FORCE_RELOAD_BIT 2
`define ART_CSR_OIE 1
`define ART_CSR_OVF 0
`define ART_ICCSR_CS_LO 0
`define ART_ICCSR_CIE_LO 2
`define ART_ICCSR_CF_LO 4
`define ART_RESET_BYTE 8'h00
`define ART_PRESCALE_W 7
`endif

// [hw/art_pkg.sv]
// Shared types for the auto-reload PWM timer.
package art_pkg;
  typedef logic [7:0] art_byte_t;
  typedef enum logic [1:0] {
    ART_CLK_CPU = 2'h0,
    ART_CLK_EXT = 2'h1
  } art_clk_src_t;
endpackage

// [hw/art_sync.sv]
// Three-stage synchroniser with agreement check on the last two stages.
`timescale 1ns/1ps
`default_nettype none
module art_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_q,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second; a change counts when stages two and three agree.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  // Edges of the filtered level.
  assign rise = (s2_q == s3_q) && s3_q && !level_q;
  assign fall = (s2_q == s3_q) && !s3_q && level_q;
endmodule
`default_nettype wire

// [hw/art_capture.sv]
// One input-capture channel with edge select, blocking flag and read clear.
`timescale 1ns/1ps
`default_nettype none
module art_capture (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_rise,
  input wire logic pin_fall,
  input wire logic edge_rising,
  input wire logic [7:0] count,
  input wire logic rd_clear,
  output logic flag_q,
  output logic [7:0] value_q,
  output logic hit
);
  assign hit = edge_rising ? pin_rise : pin_fall;

  // Latch only while the flag is clear, so an unread value is never overwritten.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
      value_q <= 8'h00;
    end else if (hit && !flag_q) begin
      flag_q <= 1'b1; // [R20]
      value_q <= count; // [R20]
    end else if (rd_clear) begin
      flag_q <= 1'b0; // [R21]
    end
  end

  // A held flag keeps the stored value unchanged whatever edges follow.
  capture_blocked_a: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
    flag_q && !rd_clear |=> $stable(value_q) && flag_q)
    else $error("capture overwritten");
endmodule
`default_nettype wire

// [test/art_pins_model.sv]
// Pin-side model: external count clock and capture inputs driven on command.
`timescale 1ns/1ps
`default_nettype none
module art_pins_model (
  input wire logic sys_clk,
  output logic ext_clk,
  output logic [1:0] cap_pin
);
  // Idle low, so the counter sees no event outside a burst.
  initial begin
    ext_clk = 1'b0;
    cap_pin = 2'h0;
  end
  // Each half lasts longer than the synchroniser, so every pulse is one event.
  task automatic pulse_clk(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge sys_clk);
      ext_clk <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ext_clk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
  endtask
  // Toggle one capture input, then let the edge pass the synchroniser.
  task automatic toggle_cap(input int i);
    @(posedge sys_clk);
    cap_pin[i] <= ~cap_pin[i];
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [test/auto_reload_pwm_timer_tb_top.sv]
// Self-checking bench for the auto-reload PWM timer.
`timescale 1ns/1ps
`default_nettype none
`include "art_params.svh"
module auto_reload_pwm_timer_tb_top;
  logic sys_clk, rst, reg_wr, reg_rd, halt_mode, rd_seen;
  logic [3:0] reg_addr, pwm_output_pin, pwm_output_oe;
  logic [7:0] reg_wdata, reg_rdata;
  logic ext_clk, overflow_irq, capture_irq, halt_wakeup;
  logic [1:0] cap_pin;
  art_pkg::art_byte_t exp_q[$], msk_q[$];
  art_pkg::art_byte_t d;
  int error_cnt = 0, num_checks = 0, n, hi, lo, chg;

  art_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_count_clock_pin(ext_clk), .capture_input_pin(cap_pin), .halt_mode(halt_mode),
    .pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq), .halt_wakeup(halt_wakeup));
  art_pins_model PINS (.sys_clk(sys_clk), .ext_clk(ext_clk), .cap_pin(cap_pin));

  // Free-running 40 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input art_pkg::art_byte_t seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input art_pkg::art_byte_t v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // The expectation is noted before the strobe; the monitor compares later.
  task automatic rd(input logic [3:0] a, input art_pkg::art_byte_t e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return pwm_output_pin[0];
      1: return capture_irq;
      2: return halt_wakeup;
      default: return ~pwm_output_pin[0];
    endcase
  endfunction

  // Bounded wait; n is the number of edges it took.
  task automatic wait_bit(input int sel, output int n);
    n = 0;
    // Sampled mid-cycle, where the registered outputs have settled.
    do begin
      @(negedge sys_clk);
      n++;
    end while (sig(sel) !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      error_cnt++;
      $display("mismatch wait %0d expected 1 seen 0", sel);
      report_and_stop();
    end else begin
      num_checks++;
    end
  endtask

  // Read data appear in the cycle after the strobe, so look mid-cycle in that cycle.
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      check("reg_rdata", reg_rdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, halt_mode} = 4'h8;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    void'($urandom(74716));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ART_ADDR_CSR, 8'h00, 8'hff);
    rd(`ART_ADDR_CAR, 8'h00, 8'hff);
    rd(4'hc, 8'h00, 8'hff);
    // Counter stays put while stopped, and a write made while stopped is kept.
    wr(`ART_ADDR_CAR, 8'h55);
    repeat (20) @(posedge sys_clk);
    rd(`ART_ADDR_CAR, 8'h55, 8'hff);
    wr(`ART_ADDR_CSR, 8'h06);
    rd(`ART_ADDR_CSR, 8'h02, 8'hff);
    wr(`ART_ADDR_ARR, 8'hf0);
    wr(`ART_ADDR_PWM_CHANNEL_CONTROL_REG, 8'hff);
    repeat (2) @(posedge sys_clk);
    check("pwm_oe", {4'h0, pwm_output_oe}, 8'h0f);
    // Each tap: period and high time, after one overflow has loaded the duty.
    for (int k = 0; k < 8; k++) begin
      d = 8'hf1 + 8'($urandom % 15);
      wr(`ART_ADDR_DCR0, d);
      wr(`ART_ADDR_CSR, 8'(k << 4) | 8'h0c);
      wait_bit(3, n);
      wait_bit(0, n);
      wait_bit(3, n);
      wait_bit(0, n);
      wait_bit(3, hi);
      wait_bit(0, lo);
      check("pwm_period", 8'((hi + lo) >> k), 8'h10);
      check("pwm_step", 8'((hi | lo) % (1 << k)), 8'h00);
      check("pwm_high", 8'(hi >> k), d - 8'hf0);
    end
    // Fastest tap, so a running waveform would move within the window.
    wr(`ART_ADDR_CSR, 8'h08);
    halt_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chg = 0;
    d = {4'h0, pwm_output_pin};
    repeat (300) begin
      @(posedge sys_clk);
      if ({4'h0, pwm_output_pin} !== d) chg++;
    end
    check("pwm_halt", 8'(chg), 8'h00);
    halt_mode <= 1'b0;
    wr(`ART_ADDR_PWM_CHANNEL_CONTROL_REG, 8'h0f);
    repeat (2) @(posedge sys_clk);
    check("pwm_oe", {4'h0, pwm_output_oe}, 8'h00);
    // Sticky overflow flag with interrupt, cleared by reading.
    wr(`ART_ADDR_CSR, 8'h0a);
    repeat (100) @(posedge sys_clk);
    wr(`ART_ADDR_CSR, 8'h02);
    repeat (2) @(posedge sys_clk);
    check("ovf_irq", {7'h0, overflow_irq}, 8'h01);
    rd(`ART_ADDR_CSR, 8'h03, 8'hff);
    rd(`ART_ADDR_CSR, 8'h02, 8'hff);
    repeat (3) @(posedge sys_clk);
    check("ovf_irq", {7'h0, overflow_irq}, 8'h00);
    // Event counting: reload fd means three pin events per overflow.
    wr(`ART_ADDR_ARR, 8'hfd);
    wr(`ART_ADDR_CSR, 8'h8c);
    rd(`ART_ADDR_CSR, 8'h88, 8'hff);
    PINS.pulse_clk(2);
    rd(`ART_ADDR_CSR, 8'h88, 8'hff);
    PINS.pulse_clk(1);
    rd(`ART_ADDR_CSR, 8'h89, 8'hff);
    rd(`ART_ADDR_CAR, 8'hfd, 8'hff);
    wr(`ART_ADDR_CSR, 8'h00);
    // Capture locks its value until the register is read.
    wr(`ART_ADDR_CAR, 8'h3c);
    wr(`ART_ADDR_ICCSR, 8'h05);
    PINS.toggle_cap(0);
    wait_bit(1, n);
    rd(`ART_ADDR_ICCSR, 8'h15, 8'h3f);
    wr(`ART_ADDR_CAR, 8'h77);
    PINS.toggle_cap(0);
    PINS.toggle_cap(0);
    check("cap_irq", {7'h0, capture_irq}, 8'h01);
    rd(`ART_ADDR_ICR0, 8'h3c, 8'hff);
    repeat (3) @(posedge sys_clk);
    check("cap_irq", {7'h0, capture_irq}, 8'h00);
    rd(`ART_ADDR_ICR1, 8'h00, 8'hff);
    // Counter already stopped before Halt; a rising capture edge wakes.
    halt_mode <= 1'b1;
    fork
      begin
        PINS.toggle_cap(0);
        PINS.toggle_cap(0);
      end
      wait_bit(2, n);
    join
    halt_mode <= 1'b0;
    // Second capture input with its own edge select and enable.
    wr(`ART_ADDR_ICCSR, 8'h0a);
    wr(`ART_ADDR_CAR, 8'h5a);
    repeat (2) @(posedge sys_clk);
    check("cap_irq", {7'h0, capture_irq}, 8'h00);
    PINS.toggle_cap(1);
    wait_bit(1, n);
    rd(`ART_ADDR_ICR1, 8'h5a, 8'hff);
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
